/* File: hdl/ddp_regs.vh */
`ifndef DDP_REGS_VH
`define DDP_REGS_VH
// word indices, not byte addresses on the bus: printed offsets other than C0H are not multiples of four
`define DDP_IDX_PTR_LOW     8'h82
`define DDP_IDX_PTR_HIGH    8'h83
`define DDP_IDX_AUX_CTRL    8'hA2
`define DDP_IDX_PTR_OPS     8'hC0
`define DDP_IDX_ACTIVE_PTR  8'hC1
`define DDP_IDX_SERIAL_CMD  8'hC2
`define DDP_IDX_SERIAL_DATA 8'hC3
`define DDP_ADDR_W          10
`define DDP_PTR_RESET       16'h0000
`define DDP_AUX_RESET       8'h00
`define DDP_AUX_SEL_BIT     0
`define DDP_AUX_ZERO_BIT    1
`define DDP_AUX_FLAG_BIT    3
`define DDP_OP_INC_AUX_BIT  0
`define DDP_OP_INC_PTR_BIT  1
`define DDP_SERIAL_W        96
`define DDP_SERIAL_BYTES    12
`define DDP_SERIAL_IDX_W    4
// arbitrary value; each part is given its own at build time
`define DDP_SERIAL_DEFAULT  96'h0123_4567_89AB_CDEF_0011_2233
`endif

/* File: hdl/ddp_serial_rom.v */
`timescale 1ns/100ps
`include "ddp_regs.vh"
module ddp_serial_rom
#(
  parameter [`DDP_SERIAL_W-1:0] SERIAL_VALUE = `DDP_SERIAL_DEFAULT
)
(
  input  wire                         core_clk,
  input  wire                         rst_n,
  input  wire                         readReq,
  input  wire [`DDP_SERIAL_IDX_W-1:0] byteIndex,
  output reg  [7:0]                   byteData
);
  wire [7:0] romBytes [0:`DDP_SERIAL_BYTES-1];
  genvar g;
  generate
    for (g = 0; g < `DDP_SERIAL_BYTES; g = g + 1)
    begin : gByte
      assign romBytes[g] = SERIAL_VALUE[g*8 +: 8];
    end
  endgenerate

  // only reachable through the programming command path
  always @(posedge core_clk)
  begin
    if (!rst_n)
      byteData <= 8'h00;
    else if (readReq)
    begin
      if (byteIndex < `DDP_SERIAL_BYTES)
        byteData <= romBytes[byteIndex];
      else
        byteData <= 8'h00;
    end
  end
endmodule // ddp_serial_rom

/* File: hdl/ddp_dual_pointer.v */
// Notes on behaviour
// - two independent 16-bit pointers, each a low byte and a high byte
// - auxiliary bit 0 selects active pointer; 0 is pointer zero, the default
// - deselected pointer keeps its value until reselected and written
// - auxiliary bit 1 always reads zero; writes ignored
// - incrementing auxiliary register toggles only the select bit
// - auxiliary bit 3 is a free software flag, no hardware effect
// - low byte at 82H, read/write, resets to zero
// - high byte at 83H, read/write, resets to zero
// - byte registers reach the selected pointer; it drives memory address
// - 96-bit serial number readable only via programming command path
`timescale 1ns/100ps
`include "ddp_regs.vh"
module ddp_dual_pointer
(
  input  wire                    core_clk,
  input  wire                    rst_n,
  input  wire                    wb_cyc_i,
  input  wire                    wb_stb_i,
  input  wire                    wb_we_i,
  input  wire [`DDP_ADDR_W-1:0]  wb_adr_i,
  input  wire [3:0]              wb_sel_i,
  input  wire [31:0]             wb_dat_i,
  output reg  [31:0]             wb_dat_o,
  output reg                     wb_ack_o,
  output reg                     wb_err_o,
  input  wire                    ptrLoad,
  input  wire [15:0]             ptrLoadValue,
  input  wire                    ptrIncrement,
  input  wire                    auxIncrement,
  output wire [15:0]             memAddress,
  output wire                    pointerSelect,
  output wire                    userFlag
);
  reg  [15:0] pointerZero;
  reg  [15:0] pointerOne;
  reg         selBit;
  reg         flagBit;
  reg  [`DDP_SERIAL_IDX_W-1:0] serialIndex;
  wire [7:0]  serialByte;
  reg         serialReq;
  reg  [7:0]  next_readByte;
  reg         addrHit;
  wire        busReq;
  wire        wrStrobe;
  wire [15:0] activePtr;
  wire [7:0]  auxValue;

  wire        hitLow;
  wire        hitHigh;
  wire        hitAux;
  wire        hitOps;
  wire        hitScmd;

  wire        wrLow;
  wire        wrHigh;
  wire        wrAux;
  wire        wrOps;
  wire        wrScmd;

  wire        opIncAux;
  wire        opIncPtr;
  wire        toggleSel;
  reg         next_selBit;
  reg         next_flagBit;
  reg         next_ack;
  reg         next_err;
  reg  [31:0] next_readOut;
  reg  [`DDP_SERIAL_IDX_W-1:0] next_serialIndex;

  localparam [7:0] IDX_LOW  = `DDP_IDX_PTR_LOW;
  localparam [7:0] IDX_HIGH = `DDP_IDX_PTR_HIGH;
  localparam [7:0] IDX_AUX  = `DDP_IDX_AUX_CTRL;
  localparam [7:0] IDX_OPS  = `DDP_IDX_PTR_OPS;
  localparam [7:0] IDX_ACT  = `DDP_IDX_ACTIVE_PTR;
  localparam [7:0] IDX_SCMD = `DDP_IDX_SERIAL_CMD;
  localparam [7:0] IDX_SDAT = `DDP_IDX_SERIAL_DATA;

  function isReg;
    input [`DDP_ADDR_W-1:0] adr;
    input [7:0]             idx;
    begin
      isReg = (adr == {idx, 2'b00});
    end
  endfunction

  ddp_serial_rom uSerial
  (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .readReq   (serialReq),
    .byteIndex (serialIndex),
    .byteData  (serialByte)
  );

  // ack/err gate stops a held request being taken twice
  assign busReq     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  // only lane 0 carries register data
  assign wrStrobe   = busReq && wb_we_i && wb_sel_i[0] && addrHit;
  assign activePtr  = selBit ? pointerOne : pointerZero;
  assign memAddress = activePtr;
  assign pointerSelect = selBit;
  assign userFlag   = flagBit;
  // bit 1 tied low, upper status bits live elsewhere
  assign auxValue   = {4'h0, flagBit, 1'b0, 1'b0, selBit};

  // write decode shared by every storage process below
  assign hitLow     = isReg(wb_adr_i, IDX_LOW);
  assign hitHigh    = isReg(wb_adr_i, IDX_HIGH);
  assign hitAux     = isReg(wb_adr_i, IDX_AUX);
  assign hitOps     = isReg(wb_adr_i, IDX_OPS);
  assign hitScmd    = isReg(wb_adr_i, IDX_SCMD);

  assign wrLow      = wrStrobe && hitLow;
  assign wrHigh     = wrStrobe && hitHigh;
  assign wrAux      = wrStrobe && hitAux;
  assign wrOps      = wrStrobe && hitOps;
  assign wrScmd     = wrStrobe && hitScmd;

  assign opIncAux   = wrOps && wb_dat_i[`DDP_OP_INC_AUX_BIT];
  assign opIncPtr   = wrOps && wb_dat_i[`DDP_OP_INC_PTR_BIT];
  // core pulse and bus op fold into one toggle request
  assign toggleSel  = auxIncrement || opIncAux;

  always @*
  begin
    addrHit = 1'b0;
    next_readByte = 8'h00;
    if (isReg(wb_adr_i, IDX_LOW))
    begin
      addrHit = 1'b1;
      next_readByte = activePtr[7:0];
    end
    else if (isReg(wb_adr_i, IDX_HIGH))
    begin
      addrHit = 1'b1;
      next_readByte = activePtr[15:8];
    end
    else if (isReg(wb_adr_i, IDX_AUX))
    begin
      addrHit = 1'b1;
      next_readByte = auxValue;
    end
    else if (isReg(wb_adr_i, IDX_OPS))
    begin
      // strobe-only register, reads as zero
      addrHit = 1'b1;
    end
    else if (isReg(wb_adr_i, IDX_ACT))
    begin
      addrHit = 1'b1;
      next_readByte = {7'h00, selBit};
    end
    else if (isReg(wb_adr_i, IDX_SCMD))
    begin
      addrHit = 1'b1;
      next_readByte = {4'h0, serialIndex};
    end
    else if (isReg(wb_adr_i, IDX_SDAT))
    begin
      addrHit = 1'b1;
      next_readByte = serialByte;
    end
  end

  // single-cycle answer; ack drops the cycle after it was given
  always @*
  begin
    next_ack     = busReq && addrHit;
    next_err     = busReq && !addrHit;
    next_readOut = 32'h0000_0000;
    if (busReq && addrHit && !wb_we_i)
    begin
      next_readOut = {24'h00_0000, next_readByte};
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_err_o <= next_err;
      wb_dat_o <= next_readOut;
    end
  end

  // programming path: writing the index fetches one serial byte
  always @*
  begin
    next_serialIndex = serialIndex;
    if (wrScmd)
    begin
      next_serialIndex = wb_dat_i[`DDP_SERIAL_IDX_W-1:0];
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      serialIndex <= {`DDP_SERIAL_IDX_W{1'b0}};
      serialReq   <= 1'b0;
    end
    else
    begin
      serialReq   <= wrScmd;
      serialIndex <= next_serialIndex;
    end
  end

  // bus write beats core increment in the same cycle
  always @*
  begin
    next_selBit  = selBit;
    next_flagBit = flagBit;
    if (wrAux)
    begin
      next_selBit  = wb_dat_i[`DDP_AUX_SEL_BIT];
      next_flagBit = wb_dat_i[`DDP_AUX_FLAG_BIT];
    end
    else if (toggleSel)
    begin
      // carry into bit 1 discarded
      next_selBit = ~selBit;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      selBit  <= 1'b0;
      flagBit <= 1'b0;
    end
    else
    begin
      selBit  <= next_selBit;
      flagBit <= next_flagBit;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : gPtr
      reg  [15:0] ptrReg;
      reg  [15:0] next_ptrReg;
      wire        isActive;
      // only the selected pointer moves; the other holds
      assign isActive = (p == 1) ? selBit : !selBit;

      always @*
      begin
        next_ptrReg = ptrReg;
        if (isActive)
        begin
          if (wrLow)
          begin
            next_ptrReg[7:0] = wb_dat_i[7:0];
          end
          else if (wrHigh)
          begin
            next_ptrReg[15:8] = wb_dat_i[7:0];
          end
          else if (ptrLoad)
          begin
            next_ptrReg = ptrLoadValue;
          end
          else if (ptrIncrement || opIncPtr)
          begin
            // low byte carries into high byte
            next_ptrReg = ptrReg + 16'h0001;
          end
        end
      end

      always @(posedge core_clk)
      begin
        if (!rst_n)
          ptrReg <= `DDP_PTR_RESET;
        else
          ptrReg <= next_ptrReg;
      end
    end
  endgenerate

  // flat names for the shared read mux
  always @*
  begin
    pointerZero = gPtr[0].ptrReg;
    pointerOne  = gPtr[1].ptrReg;
  end
endmodule // ddp_dual_pointer

/* File: sim/ddp_dual_pointer_properties.sv */
`timescale 1ns/100ps
module ddp_dual_pointer_properties
(
  input wire core_clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire ptrLoad,
  input wire [15:0] ptrLoadValue,
  input wire ptrIncrement,
  input wire auxIncrement,
  input wire [15:0] memAddress,
  input wire pointerSelect,
  input wire userFlag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // bus cycles void the select and pointer hold checks; only bus writes void the flag hold check
  wire req = wb_cyc_i && wb_stb_i;
  bus_answer_a: assert property (
    req && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o) else $error("no answer");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("long ack");
  aux_read_a: assert property (
    wb_ack_o && wb_adr_i == 10'h288 |-> (wb_dat_o & 32'hFFFF_FFF6) == 0) else $error("aux bits");
  sel_toggle_a: assert property (
    auxIncrement && !req |=> pointerSelect != $past(pointerSelect)) else $error("no toggle");
  sel_hold_a: assert property (
    !auxIncrement && !req |=> $stable(pointerSelect)) else $error("select moved");
  flag_hold_a: assert property (
    !(req && wb_we_i) |=> $stable(userFlag)) else $error("flag moved");
  ptr_inc_a: assert property (
    ptrIncrement && !ptrLoad && !auxIncrement && !req
    |=> memAddress == 16'($past(memAddress) + 16'h0001)) else $error("bad increment");
  ptr_load_a: assert property (
    ptrLoad && !auxIncrement && !req |=> memAddress == $past(ptrLoadValue)) else $error("bad load");
  aux_mirror_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 10'h288
    |-> wb_dat_o[3] == $past(userFlag) && wb_dat_o[0] == $past(pointerSelect))
    else $error("aux read mismatch");
  low_mirror_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 10'h208
    |-> wb_dat_o[7:0] == $past(memAddress[7:0])) else $error("low read mismatch");
  ptr_keep_a: assert property (
    !req && !ptrLoad && !ptrIncrement && !auxIncrement |=> $stable(memAddress))
    else $error("pointer moved");
endmodule // ddp_dual_pointer_properties
bind ddp_dual_pointer ddp_dual_pointer_properties ddp_props (.*);

/* File: sim/test_dual_data_pointer.sv */
`timescale 1ns/100ps
`include "ddp_regs.vh"
module test_dual_data_pointer;
  logic core_clk = 0;
  logic rst_n = 0;
  logic wb_cyc_i = 0;
  logic wb_stb_i = 0;
  logic wb_we_i = 0;
  logic [9:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = '0;
  logic ptrLoad = 0;
  logic ptrIncrement = 0;
  logic auxIncrement = 0;
  logic [15:0] ptrLoadValue = '0;
  logic [31:0] seed = 32'h0000_D47F;
  logic [9:0] expq[$];
  logic [9:0] e;
  logic [15:0] v;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire wb_err_o;
  wire [15:0] memAddress;
  wire pointerSelect;
  wire userFlag;
  int miscompares = 0;
  int num_checks = 0;
  ddp_dual_pointer DUT (.*);
  always #25 core_clk = ~core_clk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [8:0] x);
    expq.push_back({!w, x});
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h00_0000, d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // core pulses never overlap a bus cycle, so priority never decides a result
  task automatic pulse(input logic [2:0] p, input logic [15:0] lv);
    @(posedge core_clk);
    {ptrLoad, ptrIncrement, auxIncrement} <= p;
    ptrLoadValue <= lv;
    @(posedge core_clk);
    {ptrLoad, ptrIncrement, auxIncrement} <= 3'h0;
  endtask
  always @(posedge core_clk)
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1)
    begin
      e = expq.pop_front();
      num_checks++;
      if ({wb_err_o, (e[9] && !e[8]) ? wb_dat_o[7:0] : e[7:0]} !== e[8:0])
      begin
        $display("unexpected bus result: expected %h seen %h", e[8:0], {wb_err_o, wb_dat_o[7:0]});
        miscompares++;
      end
    end
  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    bus(0, 10'h208, 0, 9'h000);
    bus(0, 10'h20C, 0, 9'h000);
    bus(0, 10'h288, 0, 9'h000);
    $display("test reset done");
    v = rnd();
    bus(1, 10'h208, v[7:0], 0);
    bus(1, 10'h20C, v[15:8], 0);
    pulse(3'h1, 0);
    bus(0, 10'h304, 0, 9'h001);
    bus(0, 10'h208, 0, 9'h000);
    bus(1, 10'h208, 8'h5A, 0);
    bus(1, 10'h300, 8'h01, 0);
    bus(0, 10'h208, 0, {1'b0, v[7:0]});
    bus(0, 10'h20C, 0, {1'b0, v[15:8]});
    $display("test swap done");
    bus(1, 10'h288, 8'hFF, 0);
    bus(0, 10'h288, 0, 9'h009);
    pulse(3'h1, 0);
    bus(0, 10'h288, 0, 9'h008);
    bus(0, 10'h208, 0, {1'b0, v[7:0]});
    bus(1, 10'h288, 8'h00, 0);
    bus(0, 10'h288, 0, 9'h000);
    $display("test aux done");
    v = 16'(rnd());
    v[7:0] = 8'hFF;
    pulse(3'h4, v);
    pulse(3'h2, 16'hFFFF);
    bus(0, 10'h208, 0, 9'h000);
    bus(0, 10'h20C, 0, {1'b0, 8'(v[15:8] + 8'h01)});
    bus(1, 10'h300, 8'h02, 0);
    bus(0, 10'h208, 0, 9'h001);
    $display("test load done");
    for (int i = 0; i < 12; i++)
    begin
      bus(1, 10'h308, 8'(i), 0);
      bus(0, 10'h30C, 0, {1'b0, 8'(`DDP_SERIAL_DEFAULT >> (8 * i))});
    end
    bus(0, 10'h3FC, 0, 9'h100);
    $display("test serial done");
    tally_and_finish();
  end
endmodule // test_dual_data_pointer
